// file: hdl/mnc_pkg.sv
package mnc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LP = 6'h05;
  localparam logic [5:0] IDX_EXP = 6'h06;
  localparam logic [5:0] IDX_PHYST = 6'h10;
  localparam logic [5:0] IDX_PCS = 6'h16;
  localparam logic [5:0] IDX_NONE = 6'h3f;
  // basic_control fields
  localparam int CTL_SPEED = 13;
  localparam int CTL_NEGOTIATE_ENABLE_STRAP = 12;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam logic [15:0] CTL_WMASK = 16'h3700;
  localparam logic [15:0] CTL_RST_VAL = 16'h3100;
  // ability_advertisement fields: [8:5] = 100 full, 100 half, 10 full, 10 half
  localparam int ADV_HI = 8;
  localparam int ADV_LO = 5;
  localparam logic [4:0] SEL_FIELD = 5'h01;
  localparam logic [15:0] ADV_RST_VAL = 16'h01e1;
  // partner_ability fields and parallel-detect images
  localparam int LP_NP = 15;
  localparam int LP_RF = 13;
  localparam logic [15:0] LP_PD100 = 16'h0081;
  localparam logic [15:0] LP_PD10 = 16'h0021;
  // coding_sublayer_control fields
  localparam int PCS_FIBER = 6;
  localparam logic [15:0] PCS_FIBER_SET = 16'h004b;
  localparam logic [15:0] PCS_RST_VAL = 16'h0000;
  // basic_status constant abilities, preamble suppression, extended caps
  localparam logic [15:0] STAT_FIXED = 16'h7849;
  localparam logic LOCAL_NP = 1'b0;
  // timing
  localparam int BREAK_MS = 1500;
  localparam int CLK_KHZ = 200000;
  localparam int BREAK_CYC = BREAK_MS * CLK_KHZ;
  localparam int STRAP_SETTLE = 5;

  typedef struct packed {
    logic negotiate_enable_strap;
    logic ab_high;
    logic ab_low;
    logic fiber_n;
  } mnc_strap_t;

  localparam mnc_strap_t STRAP_RST = 4'h1;

  typedef struct packed {
    logic link;
    logic speed100;
    logic full;
    logic an_done;
  } mnc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BREAK = 4'h2,
    ST_SEND = 4'h4,
    ST_DONE = 4'h8
  } mnc_state_t;

  // strap pattern to advertisement nibble {100f,100h,10f,10h}
  function automatic logic [3:0] strap_adv(input mnc_strap_t s);
    logic [3:0] r;
    r = 4'h0;
    case ({s.negotiate_enable_strap, s.ab_high, s.ab_low})
      3'h0: r = 4'h1;
      3'h1: r = 4'h2;
      3'h2: r = 4'h4;
      3'h3: r = 4'h8;
      3'h4: r = 4'h3;
      3'h5: r = 4'hc;
      3'h6: r = 4'h8;
      default: r = 4'hf;
    endcase
    return r;
  endfunction
endpackage

// file: hdl/mnc_media_autoneg.sv
`timescale 1ns/1ps
module mnc_media_autoneg #(
  parameter int BREAK_CYC = mnc_pkg::BREAK_CYC,
  parameter int STRAP_SETTLE = mnc_pkg::STRAP_SETTLE
) (
  input wire logic ref_clk, // 200 MHz
  input wire logic arst_n, // async reset
  input wire logic clk_en, // freezes all state when low
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // always okay
  input wire mnc_pkg::mnc_strap_t strap_pins, // configuration straps
  input wire logic page_rx_valid, // partner code word received
  input wire logic [15:0] page_rx_word, // partner code word
  input wire logic pd_link_100, // 100M link signals seen
  input wire logic pd_link_10, // 10M link pulses seen
  input wire logic link_good, // link integrity
  output logic burst_en, // send pulse bursts
  output logic [15:0] burst_word, // word carried in bursts
  output mnc_pkg::mnc_mode_t link_mode, // resolved mode
  output logic fiber_mode // fiber medium selected
);
  logic rst_q1;
  logic rst_n;
  mnc_pkg::mnc_strap_t s1;
  mnc_pkg::mnc_strap_t s2;
  mnc_pkg::mnc_strap_t s3;
  mnc_pkg::mnc_strap_t strap_st;
  logic [3:0] settle_r;
  logic strap_done_r;
  logic strap_load;
  logic ph_valid_r;
  logic ph_write_r;
  logic [5:0] ph_idx_r;
  logic hready_r;
  logic hresp_r;
  logic [31:0] hrdata_r;
  logic [15:0] rd_mux;
  logic wr;
  logic rd;
  logic [15:0] bctl_r;
  logic [15:0] adv_r;
  logic [15:0] pcs_r;
  logic [15:0] lp_r;
  logic [15:0] base_r;
  logic first_r;
  logic page_rcv_r;
  logic lp_able_r;
  logic pd_fault_r;
  mnc_pkg::mnc_state_t st_r;
  logic [31:0] brk_cnt_r;
  mnc_pkg::mnc_mode_t mode_r;
  logic burst_en_r;
  logic restart_req;
  logic an_rise;
  logic [3:0] common;
  logic page_final;
  logic pd_single;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else if (clk_en) begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // three-stage strap sync; a bit moves only when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= mnc_pkg::STRAP_RST;
      s2 <= mnc_pkg::STRAP_RST;
      s3 <= mnc_pkg::STRAP_RST;
      strap_st <= mnc_pkg::STRAP_RST;
    end else if (clk_en) begin
      s1 <= strap_pins;
      s2 <= s1;
      s3 <= s2;
      strap_st <= (s2 & s3) | (strap_st & (s2 | s3));
    end
  end

  // one-shot capture once the sync chain has settled after reset
  assign strap_load = !strap_done_r && (settle_r == 4'(STRAP_SETTLE));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 4'h0;
      strap_done_r <= 1'b0;
    end else if (clk_en && !strap_done_r) begin
      if (strap_load) begin
        strap_done_r <= 1'b1;
      end else begin
        settle_r <= settle_r + 4'h1;
      end
    end
  end

  // ahb slave: one wait state so that read data comes from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_idx_r <= mnc_pkg::IDX_NONE;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end else if (clk_en) begin
      if (hsel && htrans[1] && hready) begin
        ph_valid_r <= 1'b1;
        ph_write_r <= hwrite;
        ph_idx_r <= (|haddr[31:8]) ? mnc_pkg::IDX_NONE : haddr[7:2];
        hready_r <= 1'b0;
      end else if (ph_valid_r) begin
        ph_valid_r <= 1'b0;
        hready_r <= 1'b1;
      end
    end
  end

  assign wr = ph_valid_r && ph_write_r;
  assign rd = ph_valid_r && !ph_write_r;

  always_comb begin
    rd_mux = 16'h0000;
    case (ph_idx_r)
      mnc_pkg::IDX_CTL: rd_mux = bctl_r;
      mnc_pkg::IDX_STAT: rd_mux = mnc_pkg::STAT_FIXED | {10'h000, mode_r.an_done,
        lp_r[mnc_pkg::LP_RF], 1'b0, mode_r.link, 2'h0};
      mnc_pkg::IDX_ADV: rd_mux = adv_r;
      mnc_pkg::IDX_LP: rd_mux = lp_r;
      mnc_pkg::IDX_EXP: rd_mux = {11'h000, pd_fault_r, lp_r[mnc_pkg::LP_NP],
        mnc_pkg::LOCAL_NP, page_rcv_r, lp_able_r};
      mnc_pkg::IDX_PHYST: rd_mux = {11'h000, mode_r.an_done, 1'b0, mode_r.full,
        !mode_r.speed100, mode_r.link};
      mnc_pkg::IDX_PCS: rd_mux = pcs_r;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (clk_en && rd) begin
      hrdata_r <= {16'h0000, rd_mux};
    end
  end

  // basic_control: straps seed it once, writes win afterwards
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bctl_r <= mnc_pkg::CTL_RST_VAL;
    end else if (clk_en) begin
      if (strap_load) begin
        bctl_r <= {2'b00, strap_st.ab_high, strap_st.negotiate_enable_strap, 3'b000,
          strap_st.ab_low, 8'h00};
      end else if (wr && ph_idx_r == mnc_pkg::IDX_CTL) begin
        bctl_r <= hwdata[15:0] & mnc_pkg::CTL_WMASK;
      end else if (st_r == mnc_pkg::ST_SEND) begin
        bctl_r[mnc_pkg::CTL_RESTART] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adv_r <= mnc_pkg::ADV_RST_VAL;
    end else if (clk_en) begin
      if (strap_load) begin
        adv_r[mnc_pkg::ADV_HI:mnc_pkg::ADV_LO] <= mnc_pkg::strap_adv(strap_st);
      end else if (wr && ph_idx_r == mnc_pkg::IDX_ADV) begin
        adv_r <= {hwdata[15:5], mnc_pkg::SEL_FIELD};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcs_r <= mnc_pkg::PCS_RST_VAL;
    end else if (clk_en) begin
      if (strap_load && !strap_st.fiber_n) begin
        pcs_r <= pcs_r | mnc_pkg::PCS_FIBER_SET;
      end else if (wr && ph_idx_r == mnc_pkg::IDX_PCS) begin
        pcs_r <= hwdata[15:0];
      end
    end
  end

  assign restart_req = wr && ph_idx_r == mnc_pkg::IDX_CTL && hwdata[mnc_pkg::CTL_NEGOTIATE_ENABLE_STRAP]
    && hwdata[mnc_pkg::CTL_RESTART];
  // a forced device must see enable go from zero to one to start negotiating
  assign an_rise = wr && ph_idx_r == mnc_pkg::IDX_CTL && hwdata[mnc_pkg::CTL_NEGOTIATE_ENABLE_STRAP]
    && !bctl_r[mnc_pkg::CTL_NEGOTIATE_ENABLE_STRAP];
  // only the base page carries abilities; next pages are stored but not resolved
  assign common = adv_r[mnc_pkg::ADV_HI:mnc_pkg::ADV_LO]
    & (first_r ? page_rx_word[8:5] : base_r[8:5]);
  assign page_final = page_rx_valid && !page_rx_word[mnc_pkg::LP_NP] && (|common);
  assign pd_single = pd_link_100 ^ pd_link_10;

  // negotiation sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= mnc_pkg::ST_IDLE;
      brk_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      if (restart_req || an_rise) begin
        st_r <= mnc_pkg::ST_BREAK;
        brk_cnt_r <= 32'h0000_0000;
      end else if (!bctl_r[mnc_pkg::CTL_NEGOTIATE_ENABLE_STRAP] || !strap_done_r) begin
        st_r <= mnc_pkg::ST_IDLE;
      end else begin
        case (st_r)
          mnc_pkg::ST_IDLE: begin
            st_r <= mnc_pkg::ST_BREAK;
            brk_cnt_r <= 32'h0000_0000;
          end
          mnc_pkg::ST_BREAK: begin
            // bursts and data stay silent so the partner drops its link
            if (brk_cnt_r >= 32'(BREAK_CYC - 1)) begin
              st_r <= mnc_pkg::ST_SEND;
            end else begin
              brk_cnt_r <= brk_cnt_r + 32'h1;
            end
          end
          mnc_pkg::ST_SEND: begin
            if (page_final || (!page_rx_valid && pd_single)) begin
              st_r <= mnc_pkg::ST_DONE;
            end
          end
          mnc_pkg::ST_DONE: begin
            if (!link_good) begin
              st_r <= mnc_pkg::ST_SEND;
            end
          end
          default: st_r <= mnc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_en_r <= 1'b0;
    end else if (clk_en) begin
      burst_en_r <= (st_r == mnc_pkg::ST_SEND);
    end
  end

  // resolved mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= '0;
    end else if (clk_en) begin
      case (st_r)
        mnc_pkg::ST_IDLE: mode_r <= {link_good, bctl_r[mnc_pkg::CTL_SPEED],
          bctl_r[mnc_pkg::CTL_DUPLEX], 1'b0};
        mnc_pkg::ST_SEND: begin
          if (page_final) begin
            mode_r <= {link_good, common[3] | common[2],
              common[3] | (!common[2] & common[1]), 1'b1};
          end else if (!page_rx_valid && pd_single) begin
            mode_r <= {link_good, pd_link_100, 1'b0, 1'b1};
          end else begin
            mode_r <= '0;
          end
        end
        mnc_pkg::ST_DONE: mode_r.link <= link_good;
        default: mode_r <= '0;
      endcase
    end
  end

  // partner page store and expansion flags; a set beats a read-clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_r <= 16'h0000;
      base_r <= 16'h0000;
      first_r <= 1'b1;
      page_rcv_r <= 1'b0;
      lp_able_r <= 1'b0;
      pd_fault_r <= 1'b0;
    end else if (clk_en) begin
      if (st_r == mnc_pkg::ST_BREAK) begin
        first_r <= 1'b1;
      end
      if (st_r == mnc_pkg::ST_SEND && page_rx_valid) begin
        lp_r <= page_rx_word;
        lp_able_r <= 1'b1;
        page_rcv_r <= 1'b1;
        if (first_r) begin
          base_r <= page_rx_word;
          first_r <= 1'b0;
        end
      end else if (st_r == mnc_pkg::ST_SEND && pd_single) begin
        lp_r <= pd_link_100 ? mnc_pkg::LP_PD100 : mnc_pkg::LP_PD10;
        lp_able_r <= 1'b0;
      end else if (rd && ph_idx_r == mnc_pkg::IDX_EXP) begin
        page_rcv_r <= 1'b0;
      end
      if (st_r == mnc_pkg::ST_SEND && !page_rx_valid && pd_link_100 && pd_link_10) begin
        pd_fault_r <= 1'b1;
      end else if (rd && ph_idx_r == mnc_pkg::IDX_EXP) begin
        pd_fault_r <= 1'b0;
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign burst_en = burst_en_r;
  assign burst_word = adv_r;
  assign link_mode = mode_r;
  assign fiber_mode = pcs_r[mnc_pkg::PCS_FIBER];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  property p_fiber_strap;
    strap_load && !strap_st.fiber_n |=> (pcs_r & mnc_pkg::PCS_FIBER_SET) == 16'h004b;
  endproperty
  a_fiber_strap: assert property (p_fiber_strap) else $error("fiber strap bits not set");

  property p_forced_strap;
    strap_load && !strap_st.negotiate_enable_strap |=> !bctl_r[12]
      && bctl_r[13] == $past(strap_st.ab_high) && bctl_r[8] == $past(strap_st.ab_low);
  endproperty
  a_forced_strap: assert property (p_forced_strap) else $error("forced mode not loaded");

  property p_adv_strap;
    strap_load |=> adv_r[8:5] == mnc_pkg::strap_adv($past(strap_st));
  endproperty
  a_adv_strap: assert property (p_adv_strap) else $error("advertised set wrong");

  property p_strap_frozen;
    strap_done_r && !(wr && ph_idx_r == mnc_pkg::IDX_ADV) |=> $stable(adv_r);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("advert changed");

  sequence s_restart_wr;
    wr && ph_idx_r == mnc_pkg::IDX_CTL && hwdata[12] && hwdata[9];
  endsequence
  property p_restart;
    s_restart_wr |=> st_r == mnc_pkg::ST_BREAK ##1 !burst_en_r;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");

  sequence s_best_page;
    st_r == mnc_pkg::ST_SEND && page_rx_valid && !page_rx_word[15] && common[3];
  endsequence
  property p_priority;
    s_best_page |=> mode_r.speed100 && mode_r.full && mode_r.an_done;
  endproperty
  a_priority: assert property (p_priority) else $error("priority wrong");

  property p_pd100;
    st_r == mnc_pkg::ST_SEND && !page_rx_valid && pd_link_100 && !pd_link_10
      |=> lp_r == 16'h0081 && !lp_able_r;
  endproperty
  a_pd100: assert property (p_pd100) else $error("pd image wrong");

  property p_status_fixed;
    rd && ph_idx_r == mnc_pkg::IDX_STAT |=> hrdata_r[15:11] == 5'h0f && hrdata_r[0];
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("ability bits wrong");

  property p_phy_speed;
    rd && ph_idx_r == mnc_pkg::IDX_PHYST
      |=> hrdata_r[1] == !$past(mode_r.speed100) && hrdata_r[0] == $past(mode_r.link);
  endproperty
  a_phy_speed: assert property (p_phy_speed) else $error("speed report wrong");
endmodule

// file: sim/mnc_link_partner.sv
`timescale 1ns/1ps
module mnc_link_partner (
  input wire logic ref_clk, // device clock
  input wire logic burst_en, // device is sending pulse bursts
  input wire logic [1:0] mode, // 0 silent, 1 negotiating, 2 plain 100M signalling
  input wire logic [15:0] word, // base page offered
  output logic page_rx_valid, // page strobe
  output logic [15:0] page_rx_word, // page word
  output logic pd_link_100, // 100M link signals
  output logic pd_link_10, // 10M link pulses
  output logic link_good // link integrity
);
  logic [3:0] cnt_r;
  logic sent_r;
  initial begin
    page_rx_valid = 1'b0;
    page_rx_word = 16'h5a5a;
    cnt_r = 4'h0;
    sent_r = 1'b0;
  end
  assign pd_link_100 = (mode == 2'h2);
  assign pd_link_10 = 1'b0;
  assign link_good = (mode != 2'h0);
  // silent during the break; answers a few cycles after hearing bursts
  always @(posedge ref_clk) begin
    page_rx_valid <= 1'b0;
    // word lines wander outside the strobe so a stale value is never mistaken
    page_rx_word <= ~page_rx_word;
    if (!burst_en) begin
      cnt_r <= 4'h0;
      sent_r <= 1'b0;
    end else if (mode == 2'h1 && !sent_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h5) begin
        page_rx_valid <= 1'b1;
        page_rx_word <= word;
        sent_r <= 1'b1;
      end
    end
  end
endmodule

// file: sim/tb_mnc_media_autoneg.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %s", $time, m); end end
module tb_mnc_media_autoneg;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, page_rx_valid, pd_link_100, pd_link_10, link_good;
  logic burst_en, fiber_mode;
  logic [15:0] page_rx_word, burst_word;
  mnc_pkg::mnc_strap_t strap_pins = 4'h1;
  mnc_pkg::mnc_mode_t link_mode;
  logic [1:0] pmode = 2'h0;
  logic clk_en = 1'b1;
  logic [31:0] rd;
  int fails = 0;
  int total_checks = 0;
  // advertised nibble {100f,100h,10f,10h} by strap code {negotiate_enable_strap,ab_high,ab_low}
  logic [3:0] adv_tab [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h8, 4'hf};
  always #2.5 ref_clk = ~ref_clk;

  mnc_media_autoneg #(.BREAK_CYC(20), .STRAP_SETTLE(5)) dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .strap_pins(strap_pins),
    .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word), .pd_link_100(pd_link_100),
    .pd_link_10(pd_link_10), .link_good(link_good), .burst_en(burst_en),
    .burst_word(burst_word), .link_mode(link_mode), .fiber_mode(fiber_mode));

  mnc_link_partner lp_u (
    .ref_clk(ref_clk), .burst_en(burst_en), .mode(pmode), .word(16'h01e1),
    .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word),
    .pd_link_100(pd_link_100), .pd_link_10(pd_link_10), .link_good(link_good));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // address held until ready is seen high at an edge, then data until ready again
  task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'b00};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {16'h0, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp, input string m);
    bus(1'b0, idx, 16'h0);
    `CHK(rd, exp, m)
    `CHK(hresp, 1'b0, "response not okay")
  endtask

  task automatic do_reset(input mnc_pkg::mnc_strap_t s);
    strap_pins <= s;
    arst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    // strap capture lands eight edges after release
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic wait_an();
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    `CHK(burst_en, 1'b0, "bursts during break")
    @(negedge ref_clk);
    while (link_mode.an_done !== 1'b1 && n < 400) begin
      n++;
      @(negedge ref_clk);
    end
  endtask

  initial begin
    #400000;
    fails++;
    stop_test();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset({i[2:0], 1'b1});
      rchk(mnc_pkg::IDX_ADV, {23'h0, adv_tab[i], 5'h01}, "strap advert");
      if (i < 4) begin
        rchk(mnc_pkg::IDX_CTL, {18'h0, i[1], 4'h0, i[0], 8'h0}, "strap ctl");
        `CHK(link_mode, {1'b0, i[1], i[0], 1'b0}, "strap forced mode")
      end
    end
    $display("test straps done");
    do_reset(4'he);
    `CHK(fiber_mode, 1'b1, "fiber strap")
    rchk(mnc_pkg::IDX_PCS, 32'h4b, "fiber coding bits");
    rchk(mnc_pkg::IDX_STAT, 32'h7849, "status fixed");
    rchk(mnc_pkg::IDX_NONE, 32'h0, "unmapped read");
    strap_pins <= 4'h1;
    repeat (10) @(posedge ref_clk);
    rchk(mnc_pkg::IDX_ADV, 32'h1e1, "straps frozen");
    `CHK(fiber_mode, 1'b1, "fiber kept")
    bus(1'b1, mnc_pkg::IDX_PCS, 16'h0);
    `CHK(fiber_mode, 1'b0, "fiber by write")
    `CHK(burst_en, 1'b1, "bursts while negotiating")
    $display("test media done");
    bus(1'b1, mnc_pkg::IDX_ADV, 16'h0061);
    `CHK(burst_word, 16'h0061, "burst word")
    pmode <= 2'h1;
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h1200);
    wait_an();
    `CHK(link_mode, 4'hb, "10 full resolved")
    rchk(mnc_pkg::IDX_LP, 32'h1e1, "partner word");
    rchk(mnc_pkg::IDX_PHYST, 32'h17, "link status 10 full");
    rchk(mnc_pkg::IDX_STAT, 32'h786d, "status done");
    rchk(mnc_pkg::IDX_EXP, 32'h3, "expansion");
    rchk(mnc_pkg::IDX_EXP, 32'h1, "expansion cleared");
    bus(1'b1, mnc_pkg::IDX_ADV, 16'h01e1);
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h1200);
    wait_an();
    `CHK(link_mode, 4'hf, "100 full resolved")
    rchk(mnc_pkg::IDX_PHYST, 32'h15, "link status 100 full");
    $display("test negotiation done");
    pmode <= 2'h2;
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h1200);
    wait_an();
    `CHK(link_mode, 4'hd, "parallel 100")
    rchk(mnc_pkg::IDX_LP, 32'h81, "parallel partner word");
    $display("test parallel done");
    // state leaves done one edge after the write, mode follows one edge later
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h2000);
    repeat (2) @(negedge ref_clk);
    `CHK(link_mode, 4'hc, "forced 100 half")
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h0100);
    repeat (2) @(negedge ref_clk);
    `CHK(link_mode, 4'ha, "forced 10 full")
    // a write presented while the enable is low must leave no trace
    @(posedge ref_clk);
    clk_en <= 1'b0;
    bus(1'b1, mnc_pkg::IDX_CTL, 16'h2000);
    clk_en <= 1'b1;
    rchk(mnc_pkg::IDX_CTL, 32'h100, "frozen by enable");
    $display("test forced done");
    stop_test();
  end
endmodule
